// ---- adc_channel_clock_control.sv ----
// Converter control: APB registers, clock prescaler and conversion sequencer
//
// How it works
// (R1) Continuous mode converts back to back, reloading result
// (R2) Single mode: one conversion per start, then stop
// (R3) Reset clears the continuous-conversion bit
// (R4) Five-bit channel select field in control register
// (R5) Codes 0..14 pick external channels ascending
// (R6) Codes 15..26 and 28 unused, 27 reserved
// (R7) Codes 29/30 route high/low reference nodes
// (R8) All-ones channel code powers converter off
// (R9) Reset sets channel select to all ones
// (R10) Software waits one conversion after power-up
// (R11) Eight-bit result reloaded on every completion
// (R12) Prescaler divides by 1, 2, 4, 8, 16
// (R13) Software targets about 1 MHz converter clock
// (R14) Source bit: 1 bus clock, 0 external
// (R15) Reset selects external reference clock
// (R16) External clock only if at least 1 MHz
// (R17) Software keeps clock settings stable while converting
// (R18) Write starts conversion; done after 16-17 ticks
// (R19) Done flag set on completion, cleared by access; while irq_en is set, status bit 7 reads the written bit 7 instead
// (R20) Interrupt request at end when enabled
// (R21) Continuous results overwrite unread earlier results
// (R22) Powered-off code: no start, no update
`timescale 1ns/1ps
`include "adc_params.svh"

module adc_channel_clock_control (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        external_ref_clock,
   input  wire logic [7:0]  sar_result,
   output logic      [4:0]  channel_select,
   output logic             converter_power_on,
   output logic             sample_start,
   output logic             converter_tick,
   output logic             conversion_irq
);

   // ==========================================
   // Register bus decode
   logic access;
   logic wr_ctrl;
   logic wr_cfg;
   logic rd_result;
   logic mapped;

   // Zero-wait slave; writes, clears and errors act only in the access phase
   assign access    = psel & penable;
   assign mapped    = (paddr == `OFF_CTRL_STATUS) | (paddr == `OFF_RESULT)
                    | (paddr == `OFF_CLOCK_CFG);
   assign wr_ctrl   = access & pwrite & pstrb[0] & (paddr == `OFF_CTRL_STATUS);
   assign wr_cfg    = access & pwrite & pstrb[0] & (paddr == `OFF_CLOCK_CFG);
   assign rd_result = access & ~pwrite & (paddr == `OFF_RESULT);
   assign pready    = 1'b1;
   assign pslverr   = access & ~mapped;

   // ==========================================
   // Register state
   adc_pkg::ctrl_s         ctrl_ff;
   adc_pkg::ctrl_s         nxt_ctrl;
   adc_pkg::clk_cfg_s      cfg_ff;
   adc_pkg::clk_cfg_s      nxt_cfg;
   adc_pkg::conv_state_e   state_ff;
   adc_pkg::conv_state_e   nxt_state;
   logic                   done_ff;
   logic                   nxt_done;
   logic                   conversion_done_flag_wr_ff;
   logic                   nxt_conversion_done_flag_wr;
   logic [7:0]             result_ff;
   logic [7:0]             nxt_result;
   logic [3:0]             pre_cnt_ff;
   logic [3:0]             nxt_pre_cnt;
   logic [3:0]             tick_cnt_ff;
   logic [3:0]             nxt_tick_cnt;
   logic                   start_ff;
   logic                   nxt_start;
   logic [31:0]            rdata_ff;
   logic [31:0]            nxt_rdata;
   logic                   ext_s1_ff;
   logic                   ext_s2_ff;
   logic                   ext_s3_ff;

   // ==========================================
   // External reference clock: two-stage sync, then edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_s1_ff <= 1'b0;
         ext_s2_ff <= 1'b0;
         ext_s3_ff <= 1'b0;
      end else begin
         ext_s1_ff <= external_ref_clock;
         ext_s2_ff <= ext_s1_ff;
         ext_s3_ff <= ext_s2_ff;
      end
   end

   // ==========================================
   // Prescaler
   logic       in_tick;
   logic [3:0] pre_limit;
   logic       adc_tick;
   logic       powered_off;
   logic       done_evt;

   // Input clock edge from the chosen source
   assign in_tick = (cfg_ff.source == `SOURCE_BUS) ? 1'b1
                  : (ext_s2_ff & ~ext_s3_ff); // see (R14)

   // Divide ratio: top bit set means divide by 16
   always_comb begin
      case (cfg_ff.prescale) // see (R12)
         3'h0:    pre_limit = 4'h0;
         3'h1:    pre_limit = 4'h1;
         3'h2:    pre_limit = 4'h3;
         3'h3:    pre_limit = 4'h7;
         default: pre_limit = 4'hF;
      endcase
   end

   assign adc_tick       = in_tick & (pre_cnt_ff >= pre_limit);
   assign converter_tick = adc_tick & ~powered_off;
   assign powered_off    = (ctrl_ff.channel == `CH_POWER_OFF); // see (R8)

   // Count input edges up to the divide limit
   always_comb begin
      nxt_pre_cnt = pre_cnt_ff;
      if (powered_off) begin
         nxt_pre_cnt = 4'h0;
      end else if (in_tick) begin
         nxt_pre_cnt = adc_tick ? 4'h0 : pre_cnt_ff + 4'h1; // see (R12)
      end
   end

   // ==========================================
   // Conversion sequencer
   assign done_evt = (state_ff == adc_pkg::ST_CONVERT) & adc_tick
                   & (tick_cnt_ff == `CONV_LAST); // see (R18)

   // Start on control write, restart in continuous mode
   always_comb begin
      nxt_state    = state_ff;
      nxt_tick_cnt = tick_cnt_ff;
      nxt_start    = 1'b0;
      case (state_ff)
         adc_pkg::ST_IDLE: begin
            if (wr_ctrl && pwdata[`CH_MSB:0] != `CH_POWER_OFF) begin // see (R22)
               nxt_state    = adc_pkg::ST_CONVERT; // see (R18)
               nxt_tick_cnt = 4'h0;
               nxt_start    = 1'b1;
            end
         end
         adc_pkg::ST_CONVERT: begin
            if (wr_ctrl) begin
               // A fresh write restarts or powers down
               nxt_tick_cnt = 4'h0;
               if (pwdata[`CH_MSB:0] == `CH_POWER_OFF) begin
                  nxt_state = adc_pkg::ST_IDLE; // see (R8)
               end else begin
                  nxt_start = 1'b1;
               end
            end else if (done_evt) begin
               nxt_tick_cnt = 4'h0;
               if (ctrl_ff.continuous) begin
                  nxt_start = 1'b1; // see (R1)
               end else begin
                  nxt_state = adc_pkg::ST_IDLE; // see (R2)
               end
            end else if (adc_tick) begin
               nxt_tick_cnt = tick_cnt_ff + 4'h1;
            end
         end
         default: begin
            nxt_state = adc_pkg::ST_IDLE;
         end
      endcase
   end

   // ==========================================
   // Control, config, result and flag next values
   always_comb begin
      nxt_ctrl    = ctrl_ff;
      nxt_cfg     = cfg_ff;
      nxt_result  = result_ff;
      nxt_conversion_done_flag_wr = conversion_done_flag_wr_ff;
      if (wr_ctrl) begin
         nxt_ctrl.irq_en     = pwdata[`BIT_IRQ_EN];
         nxt_ctrl.continuous = pwdata[`BIT_CONTINUOUS]; // see (R1)
         nxt_ctrl.channel    = pwdata[`CH_MSB:0]; // see (R4)
         nxt_conversion_done_flag_wr         = pwdata[`BIT_DONE] & pwdata[`BIT_IRQ_EN];
      end
      if (wr_cfg) begin
         nxt_cfg.prescale = pwdata[`PRESCALE_MSB:`PRESCALE_LSB];
         nxt_cfg.source   = pwdata[`BIT_SOURCE]; // see (R14)
      end
      if (done_evt) begin
         nxt_result = sar_result; // see (R11) see (R21)
      end
      // Completion wins over a clearing access in the same cycle
      nxt_done = done_evt | (done_ff & ~(wr_ctrl | rd_result)); // see (R19) see (R20)
   end

   // Read data mux, registered in the setup cycle of a read
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
         case (paddr)
            `OFF_CTRL_STATUS: nxt_rdata = {24'h00_0000,
                                           ctrl_ff.irq_en ? conversion_done_flag_wr_ff : done_ff,
                                           ctrl_ff.irq_en, ctrl_ff.continuous,
                                           ctrl_ff.channel};
            `OFF_RESULT:      nxt_rdata = {24'h00_0000, result_ff};
            `OFF_CLOCK_CFG:   nxt_rdata = {24'h00_0000, cfg_ff.prescale,
                                           cfg_ff.source, 4'h0};
            default:          nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   // ==========================================
   // State registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff     <= '{irq_en: 1'b0, continuous: 1'b0, // see (R3)
                          channel: `CH_POWER_OFF};        // see (R9)
         cfg_ff      <= '{prescale: 3'h0, source: `SOURCE_EXT}; // see (R15)
         state_ff    <= adc_pkg::ST_IDLE;
         done_ff     <= 1'b0;
         conversion_done_flag_wr_ff  <= 1'b0;
         result_ff   <= 8'h00;
         pre_cnt_ff  <= 4'h0;
         tick_cnt_ff <= 4'h0;
         start_ff    <= 1'b0;
         rdata_ff    <= 32'h0000_0000;
      end else begin
         ctrl_ff     <= nxt_ctrl;
         cfg_ff      <= nxt_cfg;
         state_ff    <= nxt_state;
         done_ff     <= nxt_done;
         conversion_done_flag_wr_ff  <= nxt_conversion_done_flag_wr;
         result_ff   <= nxt_result;
         pre_cnt_ff  <= nxt_pre_cnt;
         tick_cnt_ff <= nxt_tick_cnt;
         start_ff    <= nxt_start;
         rdata_ff    <= nxt_rdata;
      end
   end

   // ==========================================
   // Outputs toward the analog side and the CPU
   assign prdata             = rdata_ff;
   assign channel_select     = ctrl_ff.channel; // see (R5) see (R6) see (R7)
   assign converter_power_on = ~powered_off;
   assign sample_start       = start_ff;
   assign conversion_irq     = ctrl_ff.irq_en & done_ff; // see (R20)

   // ==========================================
   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Bus cycles since the last start pulse; a clock change marks the count stale
   logic [4:0] conv_age_ff;
   logic [4:0] nxt_conv_age;
   always_comb begin
      nxt_conv_age = conv_age_ff;
      if (start_ff) begin
         nxt_conv_age = 5'h01;
      end else if (wr_cfg) begin
         nxt_conv_age = 5'h1F;
      end else if (conv_age_ff != 5'h1F) begin
         nxt_conv_age = conv_age_ff + 5'h01;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_age_ff <= 5'h1F;
      end else begin
         conv_age_ff <= nxt_conv_age;
      end
   end

   a_single_stops: assert property ( // see (R2)
      done_evt && !ctrl_ff.continuous && !wr_ctrl |=> state_ff == adc_pkg::ST_IDLE)
      else $error("single conversion did not stop");

   a_cont_restarts: assert property ( // see (R1)
      done_evt && ctrl_ff.continuous && !wr_ctrl
      |=> state_ff == adc_pkg::ST_CONVERT && sample_start)
      else $error("continuous conversion did not restart");

   a_result_load: assert property ( // see (R11)
      done_evt |=> result_ff == $past(sar_result))
      else $error("result not loaded on completion");

   a_done_sets: assert property ( // see (R19)
      done_evt |=> done_ff)
      else $error("done flag not set");

   a_done_clears: assert property ( // see (R19)
      (wr_ctrl || rd_result) && !done_evt |=> !done_ff)
      else $error("done flag not cleared by access");

   a_off_quiet: assert property ( // see (R22)
      powered_off |-> state_ff == adc_pkg::ST_IDLE && !done_evt && !converter_tick)
      else $error("activity while powered off");

   a_irq_raise: assert property ( // see (R20)
      done_evt && ctrl_ff.irq_en && !wr_ctrl ##1 !wr_ctrl |-> conversion_irq)
      else $error("interrupt not raised at completion");

   a_conv_ticks: assert property ( // see (R18)
      done_evt && cfg_ff.source && cfg_ff.prescale == 3'h0 && conv_age_ff != 5'h1F
      |-> conv_age_ff == {1'b0, `CONV_LAST})
      else $error("conversion length wrong");

   a_prescale_div: assert property ( // see (R12)
      adc_tick && cfg_ff.source |-> pre_cnt_ff == pre_limit)
      else $error("prescaler divide ratio wrong");

   c_single_done: cover property (
      done_evt && !ctrl_ff.continuous);
   c_cont_done: cover property (
      done_evt && ctrl_ff.continuous ##[1:300] done_evt);
   c_ref_conv: cover property (
      done_evt && ctrl_ff.channel == `CH_HIGH_REF);

endmodule

// ---- adc_params.svh ----
// Register map, field positions, reset values and timing counts of the converter control
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH
// ==========================================
// Register byte offsets
`define OFF_CTRL_STATUS 12'h000
`define OFF_RESULT      12'h004
`define OFF_CLOCK_CFG   12'h008
// ==========================================
// Status and control fields
`define BIT_DONE        7
`define BIT_IRQ_EN      6
`define BIT_CONTINUOUS  5
`define CH_MSB          4
`define CH_POWER_OFF    5'h1F
`define CH_HIGH_REF     5'h1D
`define CH_LOW_REF      5'h1E
`define CH_LAST_EXT     5'h0E
// ==========================================
// Clock config fields
`define PRESCALE_MSB    7
`define PRESCALE_LSB    5
`define BIT_SOURCE      4
`define SOURCE_BUS      1'b1
`define SOURCE_EXT      1'b0
// ==========================================
// Timing
`define CONV_TICKS      5'h10
`define CONV_LAST       4'hF
`endif

// ---- adc_pkg.sv ----
// Types shared by the converter control block
package adc_pkg;
   // ==========================================
   // Software controls of a conversion
   typedef struct packed {
      logic       irq_en;
      logic       continuous;
      logic [4:0] channel;
   } ctrl_s;
   // ==========================================
   // Converter clock selection
   typedef struct packed {
      logic [2:0] prescale;
      logic       source;
   } clk_cfg_s;
   // ==========================================
   // Conversion sequencer states
   typedef enum logic {
      ST_IDLE,
      ST_CONVERT
   } conv_state_e;
endpackage

// ---- tb_adc_channel_clock_control.sv ----
// Self-checking testbench of the converter control block
`timescale 1ns/1ps
`include "adc_params.svh"

module tb_adc_channel_clock_control;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        external_ref_clock;
   logic [7:0]  sar_result;
   logic [4:0]  channel_select;
   logic        converter_power_on;
   logic        sample_start;
   logic        converter_tick;
   logic        conversion_irq;
   int          err_total = 0;
   int          compares = 0;
   int          cycles = 0;
   int          starts = 0;
   int          ticks = 0;
   int          s0;
   int          n;
   logic [31:0] rdata;
   logic        rerr;
   int          codes [6] = '{0, 1, 2, 3, 4, 7};
   int          ratio [6] = '{1, 2, 4, 8, 16, 16};

   adc_channel_clock_control dut_u (
      .pclk               (pclk),
      .presetn            (presetn),
      .psel               (psel),
      .penable            (penable),
      .pwrite             (pwrite),
      .paddr              (paddr),
      .pwdata             (pwdata),
      .pstrb              (4'hF),
      .prdata             (prdata),
      .pready             (pready),
      .pslverr            (pslverr),
      .external_ref_clock (external_ref_clock),
      .sar_result         (sar_result),
      .channel_select     (channel_select),
      .converter_power_on (converter_power_on),
      .sample_start       (sample_start),
      .converter_tick     (converter_tick),
      .conversion_irq     (conversion_irq)
   );

   // ==========================================
   // Clocks: bus clock 8 ns, external reference 40 ns
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      external_ref_clock = 1'b0;
      forever #20 external_ref_clock = ~external_ref_clock;
   end

   // Event counters and hang guard
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (sample_start === 1'b1) starts <= starts + 1;
      if (converter_tick === 1'b1) ticks <= ticks + 1;
      if (cycles > 30000) begin
         err_total++;
         final_report();
      end
   end

   // ==========================================
   // Compare, bus and closing tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] wdata);
      logic fin;
      fin = 1'b0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= {24'h000000, wdata};
      @(posedge pclk);
      penable <= 1'b1;
      // Answer taken at the rising edge, before that edge's updates land
      while (!fin) begin
         @(posedge pclk);
         fin = (pready === 1'b1);
         rdata = prdata;
         rerr = pslverr;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] addr, input logic [7:0] exp);
      apb(1'b0, addr, 8'h00);
      chk(rdata, {24'h000000, exp});
   endtask

   task automatic idle(input int k);
      repeat (k) @(posedge pclk);
   endtask

   // Cycles between two converter ticks
   task automatic tick_gap(input int exp);
      @(negedge pclk);
      while (converter_tick !== 1'b1) @(negedge pclk);
      @(negedge pclk);
      n = 1;
      while (converter_tick !== 1'b1) begin
         @(negedge pclk);
         n++;
      end
      chk(32'(n), 32'(exp));
   endtask

   task automatic final_report();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ==========================================
   // Test sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      sar_result = 8'h00;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      // Reset state: powered off, single mode, external source
      @(negedge pclk);
      chk(32'(channel_select), 32'h0000001F);
      chk(32'(converter_power_on), 32'h00000000);
      rd(`OFF_CTRL_STATUS, 8'h1F);
      rd(`OFF_CLOCK_CFG, 8'h00);
      rd(`OFF_RESULT, 8'h00);
      // Powered-off code starts nothing
      s0 = starts;
      apb(1'b1, `OFF_CTRL_STATUS, 8'h1F);
      idle(40);
      chk(32'(starts), 32'(s0));
      // External source, divide by 1: one tick per rising reference edge
      apb(1'b1, `OFF_CLOCK_CFG, 8'h00);
      apb(1'b1, `OFF_CTRL_STATUS, 8'h23);
      s0 = ticks;
      idle(200);
      chk(32'((ticks - s0) inside {[38:42]}), 32'h00000001);
      // Bus source, prescale codes 0 to 4 and 7; converter halted while the clock changes
      foreach (codes[i]) begin
         apb(1'b1, `OFF_CTRL_STATUS, 8'h1F);
         apb(1'b1, `OFF_CLOCK_CFG, {codes[i][2:0], 5'h10});
         apb(1'b1, `OFF_CTRL_STATUS, 8'h23);
         tick_gap(ratio[i]);
      end
      // Halt, switch to divide by 1, then one settling conversion after power-up
      apb(1'b1, `OFF_CTRL_STATUS, 8'h1F);
      apb(1'b1, `OFF_CLOCK_CFG, 8'h10);
      apb(1'b1, `OFF_CTRL_STATUS, 8'h03);
      idle(30);
      // Single conversion with interrupt: timing, result, clearing
      sar_result <= 8'h3C;
      apb(1'b1, `OFF_CTRL_STATUS, 8'h43);
      n = 0;
      while (conversion_irq !== 1'b1 && n < 100) begin
         @(negedge pclk);
         n++;
      end
      chk(32'(n), 32'd17);
      s0 = starts;
      idle(60);
      chk(32'(starts), 32'(s0));
      rd(`OFF_RESULT, 8'h3C);
      @(negedge pclk);
      chk(32'(conversion_irq), 32'h00000000);
      // Completion flag set and seen on status read, cleared by result read
      apb(1'b1, `OFF_CTRL_STATUS, 8'h03);
      idle(40);
      rd(`OFF_CTRL_STATUS, 8'h83);
      rd(`OFF_RESULT, 8'h3C);
      rd(`OFF_CTRL_STATUS, 8'h03);
      // Continuous: back to back, unread results overwritten
      sar_result <= 8'hA5;
      apb(1'b1, `OFF_CTRL_STATUS, 8'h23);
      s0 = starts;
      idle(200);
      chk(32'((starts - s0) inside {[10:13]}), 32'h00000001);
      sar_result <= 8'h5A;
      idle(40);
      rd(`OFF_RESULT, 8'h5A);
      // Result is read-only, unmapped address refused
      apb(1'b1, `OFF_RESULT, 8'hFF);
      rd(`OFF_RESULT, 8'h5A);
      apb(1'b0, 12'h00C, 8'h00);
      chk({31'h0, rerr}, 32'h00000001);
      chk(rdata, 32'h00000000);
      // Every channel code reaches the multiplexer select
      for (int c = 0; c < 32; c++) begin
         apb(1'b1, `OFF_CTRL_STATUS, {3'b000, c[4:0]});
         @(negedge pclk);
         chk(32'(channel_select), 32'(c));
         chk(32'(converter_power_on), 32'(c != 31));
      end
      s0 = ticks;
      idle(20);
      chk(32'(ticks), 32'(s0));
      final_report();
   end
endmodule
